/* File: logic/dpio_pkg.sv */
// Shared constants and carrier types for the dual port I/O block with timer pins.
`default_nettype none
package dpio_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus geometry.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int PORT_W = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets; the direction registers share their slot with pin levels.
   localparam logic [ADDR_W-1:0] OFS_PORT_E_DIR_PIN   = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_PORT_F_DIR_PIN   = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_PORT_E_OUT_VALUE = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_PORT_F_OUT_VALUE = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_PORT_E_DRV_TYPE  = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_PORT_F_DRV_TYPE  = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_TIMER_PIN_SELECT = 4'h6;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions inside the timer pin select register.
   localparam int POS_TIMER_X_PIN_SELECT = 0;
   localparam int POS_TIMER_Y_PIN_SELECT = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Port F bit positions of the shared timer functions.
   localparam int POS_TIMER_A_EXT_IN      = 0;
   localparam int POS_TIMER_B_EXT_IN      = 1;
   localparam int POS_TIMER_A_COMPARE_OUT = 2;
   localparam int POS_TIMER_B_COMPARE_OUT = 3;
   localparam int POS_TIMER_X_EXT_IN      = 4;
   localparam int POS_TIMER_Y_EXT_IN      = 5;
   localparam int POS_TIMER_X_COMPARE_OUT = 6;
   localparam int POS_TIMER_Y_COMPARE_OUT = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset.
   localparam logic [PORT_W-1:0] RST_DIRECTION   = 8'h00;
   localparam logic [PORT_W-1:0] RST_OUT_VALUE   = 8'h00;
   localparam logic [PORT_W-1:0] RST_DRIVE_TYPE  = 8'h00;
   localparam logic [1:0]        RST_PIN_SELECT  = 2'h0;
   localparam logic [DATA_W-1:0] RST_READ_DATA   = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ   = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Carrier types.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } dpio_bus_req_t;

   typedef struct packed {
      logic [PORT_W-1:0] nch_on;
      logic [PORT_W-1:0] pch_on;
      logic [PORT_W-1:0] pin_out;
      logic [PORT_W-1:0] pin_oe;
   } dpio_drive_t;

   typedef struct packed {
      logic       timer_a_compare_out;
      logic       timer_b_compare_out;
      logic       timer_x_compare_out;
      logic       timer_y_compare_out;
      logic [3:0] timer_a_compare_output_select;
      logic [3:0] timer_b_compare_output_select;
      logic [3:0] timer_x_compare_output_select;
      logic [3:0] timer_y_compare_output_select;
   } dpio_timer_in_t;

   typedef struct packed {
      logic timer_a_ext_in;
      logic timer_b_ext_in;
      logic timer_x_ext_in;
      logic timer_y_ext_in;
   } dpio_timer_ext_t;

endpackage
`default_nettype wire

/* File: logic/dpio_sync.sv */
// Two-stage synchroniser for the eight levels of one port's pins.
`timescale 1ns/100ps
`default_nettype none
module dpio_sync
   import dpio_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic [PORT_W-1:0] pin_i,
   output logic      [PORT_W-1:0] level_o
);

   typedef struct packed {
      logic [PORT_W-1:0] stage1;
      logic [PORT_W-1:0] stage2;
   } dpio_sync_state_t;

   dpio_sync_state_t state_reg;
   dpio_sync_state_t state_next;

   // The first stage feeds only the second stage.
   always_comb begin
      state_next.stage1 = pin_i;
      state_next.stage2 = state_reg.stage1;
   end

   // No reset here on purpose: the stages follow the pins from the first edges.
   always_ff @(posedge clk_sys_i) begin
      state_reg <= state_next;
   end

   assign level_o = state_reg.stage2;

endmodule
`default_nettype wire

/* File: logic/dpio_pin_drive.sv */
// Per-pin driver decode from direction, output value and drive type.
`timescale 1ns/100ps
`default_nettype none
module dpio_pin_drive
   import dpio_pkg::*;
(
   input  wire logic [PORT_W-1:0] direction_i,
   input  wire logic [PORT_W-1:0] value_i,
   input  wire logic [PORT_W-1:0] drive_type_i,
   output dpio_pkg::dpio_drive_t  drive_o
);

   // Each bit is decoded on its own; input pins leave both drivers off.
   always_comb begin
      // [RL12] n-channel on for driven zero.
      drive_o.nch_on  = direction_i & ~value_i;
      // [RL9] open drain kills p-channel.
      drive_o.pch_on  = direction_i & value_i & ~drive_type_i;
      drive_o.pin_out = value_i;
      // [RL10] only output pins drive.
      drive_o.pin_oe  = drive_o.nch_on | drive_o.pch_on;
   end

endmodule
`default_nettype wire

/* File: logic/dpio_top.sv */
// Two 8-bit general purpose ports with pin readback, drive type and timer pin sharing.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// [RL1] Pin level read returns sampled pin states.
// [RL2] Pin level shares address with direction register.
// [RL3] Pin level has no fixed reset value.
// [RL4] F7 carries timer Y compare when selected.
// [RL5] F6 carries timer X compare when selected.
// [RL6] F3, F2 carry timer B, A compare.
// [RL7] F5, F4 feed timer Y, X inputs.
// [RL8] F1, F0 always feed timer B, A.
// [RL9] Drive type: zero CMOS, one open drain.
// [RL10] Drive type acts on outputs, per bit.
// [RL11] Timer-driven pins keep their drive type.
// [RL12] Zero uses n-channel; one per drive type.
// [RL13] Direction bits write-only, zero is input.
// [RL14] Output value always read/write, resets zero.
module dpio_top
   import dpio_pkg::*;
(
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_i,
   input  wire dpio_pkg::dpio_bus_req_t bus_i,
   output logic      [DATA_W-1:0]       rdata_o,
   input  wire logic [PORT_W-1:0]       port_e_pin_i,
   input  wire logic [PORT_W-1:0]       port_f_pin_i,
   output dpio_pkg::dpio_drive_t        port_e_drive_o,
   output dpio_pkg::dpio_drive_t        port_f_drive_o,
   input  wire dpio_pkg::dpio_timer_in_t timer_i,
   output dpio_pkg::dpio_timer_ext_t    timer_ext_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Register map, one byte per slot.
   //   Slot 0: port E direction on write, port E pin levels on read.
   //   Slot 1: port F direction on write, port F pin levels on read.
   //   Slot 2: port E output value, read and write.
   //   Slot 3: port F output value, read and write.
   //   Slot 4: port E drive type, one bit per pin, set for open drain.
   //   Slot 5: port F drive type, one bit per pin, set for open drain.
   //   Slot 6: timer pin gates, bit 0 for timer X and bit 1 for timer Y.
   // Every other slot reads as zero and ignores writes.

   ////////////////////////////////////////////////////////////////////////////
   // State of the block, registered as one record.
   typedef struct packed {
      logic [PORT_W-1:0] port_e_direction;
      logic [PORT_W-1:0] port_f_direction;
      logic [PORT_W-1:0] port_e_output_value;
      logic [PORT_W-1:0] port_f_output_value;
      logic [PORT_W-1:0] port_e_drive_type;
      logic [PORT_W-1:0] port_f_drive_type;
      logic              timer_x_pin_select;
      logic              timer_y_pin_select;
      logic [DATA_W-1:0] rdata;
      dpio_drive_t       port_e_drive;
      dpio_drive_t       port_f_drive;
      dpio_timer_ext_t   timer_ext;
   } dpio_state_t;

   dpio_state_t state_reg;
   dpio_state_t state_next;

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // A compare output owns its pin when its select gate is open and any
   // output select bit is set; an all-zero field hands the pin back.
   // Timers without a pin gate of their own pass a gate tied high.
   function automatic logic timer_owns_pin(input logic gate, input logic [3:0] select);
      timer_owns_pin = gate & (|select);
   endfunction

   // Write strobe decode for one register address; all slots share it, so
   // they agree on how strobe and address combine.
   function automatic logic write_hit(input dpio_bus_req_t req, input logic [ADDR_W-1:0] ofs);
      write_hit = req.wr & (req.addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; every pin comes from outside the clock domain.
   // The two stages cost two cycles on every pin read, the price of never
   // handing a metastable level to software or to a timer input.
   // The stages have no reset, so the first reads after power-up show the
   // pins as they stand rather than a fixed value.
   logic [PORT_W-1:0] port_e_pin_level;
   logic [PORT_W-1:0] port_f_pin_level;

   // [RL3] Levels follow the pins.
   dpio_sync u_sync_e (
      .clk_sys_i (clk_sys_i),
      .pin_i     (port_e_pin_i),
      .level_o   (port_e_pin_level)
   );

   dpio_sync u_sync_f (
      .clk_sys_i (clk_sys_i),
      .pin_i     (port_f_pin_i),
      .level_o   (port_f_pin_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Timer takeover of port F pins.
   // The timer signals come from logic on this clock and need no
   // synchroniser. A timer that clears its output select hands the pin
   // back to the direction and output value registers.
   logic              take_y;
   logic              take_x;
   logic              take_b;
   logic              take_a;
   logic [PORT_W-1:0] port_f_take;
   logic [PORT_W-1:0] port_f_timer_value;
   logic [PORT_W-1:0] port_f_eff_direction;
   logic [PORT_W-1:0] port_f_eff_value;

   // [RL4] Timer Y on F7.
   assign take_y = timer_owns_pin(state_reg.timer_y_pin_select,
                                  timer_i.timer_y_compare_output_select);
   // [RL5] Timer X on F6.
   assign take_x = timer_owns_pin(state_reg.timer_x_pin_select,
                                  timer_i.timer_x_compare_output_select);
   // Timers A and B have no pin gate; only the output select decides.
   // [RL6] Timers B, A ungated.
   assign take_b = timer_owns_pin(1'b1, timer_i.timer_b_compare_output_select);
   assign take_a = timer_owns_pin(1'b1, timer_i.timer_a_compare_output_select);

   // Collect the takeover flags and compare levels at their pin positions.
   // Bits that no timer can own stay zero in both masks.
   always_comb begin
      port_f_take = 8'h00;
      port_f_timer_value = 8'h00;
      port_f_take[POS_TIMER_Y_COMPARE_OUT] = take_y;
      port_f_take[POS_TIMER_X_COMPARE_OUT] = take_x;
      port_f_take[POS_TIMER_B_COMPARE_OUT] = take_b;
      port_f_take[POS_TIMER_A_COMPARE_OUT] = take_a;
      port_f_timer_value[POS_TIMER_Y_COMPARE_OUT] = timer_i.timer_y_compare_out;
      port_f_timer_value[POS_TIMER_X_COMPARE_OUT] = timer_i.timer_x_compare_out;
      port_f_timer_value[POS_TIMER_B_COMPARE_OUT] = timer_i.timer_b_compare_out;
      port_f_timer_value[POS_TIMER_A_COMPARE_OUT] = timer_i.timer_a_compare_out;
   end

   // A timer-owned pin is an output whatever its direction bit says.
   // The output value register keeps its contents meanwhile, and its value
   // returns to the pin once the timer lets go.
   assign port_f_eff_direction = state_reg.port_f_direction | port_f_take;
   assign port_f_eff_value = (port_f_take & port_f_timer_value)
                           | (~port_f_take & state_reg.port_f_output_value);

   ////////////////////////////////////////////////////////////////////////////
   // Driver decode for both ports.
   dpio_drive_t port_e_drive_comb;
   dpio_drive_t port_f_drive_comb;

   // Port E shares no pin with a timer, so its registers feed the decode.
   // [RL10] Per-bit output gating.
   // [RL12] Driver follows value.
   dpio_pin_drive u_drive_e (
      .direction_i  (state_reg.port_e_direction),
      .value_i      (state_reg.port_e_output_value),
      .drive_type_i (state_reg.port_e_drive_type),
      .drive_o      (port_e_drive_comb)
   );

   // [RL11] Timer pins use drive type.
   dpio_pin_drive u_drive_f (
      .direction_i  (port_f_eff_direction),
      .value_i      (port_f_eff_value),
      .drive_type_i (state_reg.port_f_drive_type),
      .drive_o      (port_f_drive_comb)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: register writes, read data and registered pin outputs.
   always_comb begin
      state_next = state_reg;
      // Only one strobe comes in a cycle, so the write decodes never
      // compete; a read in the cycle after a write already sees the new
      // register value.

      // [RL2] Shared slot writes direction.
      if (write_hit(bus_i, OFS_PORT_E_DIR_PIN)) begin
         state_next.port_e_direction = bus_i.wdata;
      end
      if (write_hit(bus_i, OFS_PORT_F_DIR_PIN)) begin
         state_next.port_f_direction = bus_i.wdata;
      end

      // [RL14] Output value always writable.
      if (write_hit(bus_i, OFS_PORT_E_OUT_VALUE)) begin
         state_next.port_e_output_value = bus_i.wdata;
      end
      if (write_hit(bus_i, OFS_PORT_F_OUT_VALUE)) begin
         state_next.port_f_output_value = bus_i.wdata;
      end

      // A new drive type applies to a pin that a timer owns as well.
      // [RL9] Drive type per bit.
      if (write_hit(bus_i, OFS_PORT_E_DRV_TYPE)) begin
         state_next.port_e_drive_type = bus_i.wdata;
      end
      if (write_hit(bus_i, OFS_PORT_F_DRV_TYPE)) begin
         state_next.port_f_drive_type = bus_i.wdata;
      end

      // Timer pin gates; the upper bits of this slot are not stored.
      // Software reads zeros back from the dropped bits.
      if (write_hit(bus_i, OFS_TIMER_PIN_SELECT)) begin
         state_next.timer_x_pin_select = bus_i.wdata[POS_TIMER_X_PIN_SELECT];
         state_next.timer_y_pin_select = bus_i.wdata[POS_TIMER_Y_PIN_SELECT];
      end

      // The direction registers cannot be read back, as their slots return
      // pin levels; software that needs them keeps its own copy.
      // Read data lives for exactly one cycle after the read strobe.
      state_next.rdata = RST_READ_DATA;
      if (bus_i.rd) begin
         case (bus_i.addr)
            // [RL1] Read returns pin levels.
            OFS_PORT_E_DIR_PIN: begin
               state_next.rdata = port_e_pin_level;
            end
            OFS_PORT_F_DIR_PIN: begin
               state_next.rdata = port_f_pin_level;
            end
            // [RL14] Output value reads back.
            OFS_PORT_E_OUT_VALUE: begin
               state_next.rdata = state_reg.port_e_output_value;
            end
            OFS_PORT_F_OUT_VALUE: begin
               state_next.rdata = state_reg.port_f_output_value;
            end
            OFS_PORT_E_DRV_TYPE: begin
               state_next.rdata = state_reg.port_e_drive_type;
            end
            OFS_PORT_F_DRV_TYPE: begin
               state_next.rdata = state_reg.port_f_drive_type;
            end
            // Upper bits of the pin gate slot read as zero.
            OFS_TIMER_PIN_SELECT: begin
               state_next.rdata = 8'h00;
               state_next.rdata[POS_TIMER_X_PIN_SELECT] = state_reg.timer_x_pin_select;
               state_next.rdata[POS_TIMER_Y_PIN_SELECT] = state_reg.timer_y_pin_select;
            end
            // Unmapped slots answer zero rather than stale data.
            default: begin
               state_next.rdata = UNMAPPED_READ;
            end
         endcase
      end

      // Pin drivers are registered so the pads see glitch-free controls.
      state_next.port_e_drive = port_e_drive_comb;
      state_next.port_f_drive = port_f_drive_comb;

      // A gated timer input reads zero while its pin select is clear, so a
      // timer X or Y never counts edges on a pin that software uses as plain I/O.
      // [RL7] F5, F4 gated inputs.
      state_next.timer_ext.timer_y_ext_in = state_reg.timer_y_pin_select
                                          & port_f_pin_level[POS_TIMER_Y_EXT_IN];
      state_next.timer_ext.timer_x_ext_in = state_reg.timer_x_pin_select
                                          & port_f_pin_level[POS_TIMER_X_EXT_IN];
      // [RL8] F1, F0 always feed.
      state_next.timer_ext.timer_b_ext_in = port_f_pin_level[POS_TIMER_B_EXT_IN];
      state_next.timer_ext.timer_a_ext_in = port_f_pin_level[POS_TIMER_A_EXT_IN];
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; every control bit has a constant reset value.
   // The synchroniser stages live in their own module and stay out of
   // this reset on purpose; a reset must never fake a pin level.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         // [RL13] Directions reset to input.
         state_reg.port_e_direction    <= RST_DIRECTION;
         state_reg.port_f_direction    <= RST_DIRECTION;
         state_reg.port_e_output_value <= RST_OUT_VALUE;
         state_reg.port_f_output_value <= RST_OUT_VALUE;
         state_reg.port_e_drive_type   <= RST_DRIVE_TYPE;
         state_reg.port_f_drive_type   <= RST_DRIVE_TYPE;
         state_reg.timer_x_pin_select  <= RST_PIN_SELECT[POS_TIMER_X_PIN_SELECT];
         state_reg.timer_y_pin_select  <= RST_PIN_SELECT[POS_TIMER_Y_PIN_SELECT];
         state_reg.rdata               <= RST_READ_DATA;
         // Pin controls start with every driver off, so no pin is driven
         // before software asks for it.
         state_reg.port_e_drive        <= '0;
         state_reg.port_f_drive        <= '0;
         state_reg.timer_ext           <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register.
   // A register write therefore reaches the pads one cycle after the
   // register itself changes.
   assign rdata_o        = state_reg.rdata;
   assign port_e_drive_o = state_reg.port_e_drive;
   assign port_f_drive_o = state_reg.port_f_drive;
   assign timer_ext_o    = state_reg.timer_ext;

endmodule
`default_nettype wire

/* File: verification/dpio_pins.sv */
// Board model of one port's eight pins: drivers against external levels.
`timescale 1ns/100ps
`default_nettype none
module dpio_pins
   import dpio_pkg::*;
(
   input  wire dpio_pkg::dpio_drive_t drv_i,
   input  wire logic [PORT_W-1:0]     ext_i,
   output logic      [PORT_W-1:0]     pin_o
);
   import dpio_pkg::*;
   // An n-channel driver pulls low and a p-channel driver pulls high.
   // A pin with both drivers off shows the board level, as an open drain would.
   assign pin_o = ~drv_i.nch_on & (drv_i.pch_on | ext_i);
endmodule
`default_nettype wire

/* File: verification/dpio_top_chk.sv */
// Port level assertions for the dual port I/O block.
`timescale 1ns/100ps
`default_nettype none
module dpio_top_chk
   import dpio_pkg::*;
(
   input wire logic                     clk_sys_i,
   input wire logic                     rst_i,
   input wire dpio_pkg::dpio_bus_req_t  bus_i,
   input wire logic [DATA_W-1:0]        rdata_o,
   input wire logic [PORT_W-1:0]        port_f_pin_i,
   input wire dpio_pkg::dpio_drive_t    port_e_drive_o,
   input wire dpio_pkg::dpio_drive_t    port_f_drive_o,
   input wire dpio_pkg::dpio_timer_in_t timer_i,
   input wire dpio_pkg::dpio_timer_ext_t timer_ext_o
);
   import dpio_pkg::*;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   // A pin level held for several samples has crossed the synchroniser.
   sequence s_still(logic p);
      $stable(p)[*4];
   endsequence
   // A timer owns its pin with a steady compare value.
   sequence s_own(logic [3:0] os, logic c, logic v);
      (|os && c == v)[*2];
   endsequence
   a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
      else $error("read data outside the read answer cycle");
   a_reset_quiet: assert property (disable iff (1'b0)
      rst_i && $past(rst_i) |->
      rdata_o == 8'h00 && port_e_drive_o == '0 && port_f_drive_o == '0)
      else $error("outputs active during reset");
   a_oe_matches: assert property (
      port_e_drive_o.pin_oe == (port_e_drive_o.nch_on | port_e_drive_o.pch_on)
      && port_f_drive_o.pin_oe == (port_f_drive_o.nch_on | port_f_drive_o.pch_on))
      else $error("output enable differs from driver state");
   a_no_fight: assert property (
      (port_f_drive_o.nch_on & port_f_drive_o.pch_on) == 8'h00)
      else $error("both drivers on at one pin");
   a_nch_low: assert property (
      (port_e_drive_o.nch_on & port_e_drive_o.pin_out) == 8'h00)
      else $error("n-channel driver on for a high value");
   a_pch_high: assert property (
      (port_f_drive_o.pch_on & ~port_f_drive_o.pin_out) == 8'h00)
      else $error("p-channel driver on for a low value");
   a_timer_channel_a_in: assert property (
      s_still(port_f_pin_i[0]) |-> timer_ext_o.timer_a_ext_in == port_f_pin_i[0])
      else $error("timer A input does not follow its pin");
   a_timer_channel_b_in: assert property (
      s_still(port_f_pin_i[1]) |-> timer_ext_o.timer_b_ext_in == port_f_pin_i[1])
      else $error("timer B input does not follow its pin");
   a_take_high: assert property (
      s_own(timer_i.timer_a_compare_output_select, timer_i.timer_a_compare_out, 1'b1)
      |-> !port_f_drive_o.nch_on[2] && port_f_drive_o.pin_out[2])
      else $error("timer A high compare not on its pin");
   a_take_low: assert property (
      s_own(timer_i.timer_b_compare_output_select, timer_i.timer_b_compare_out, 1'b0)
      |-> port_f_drive_o.nch_on[3])
      else $error("timer B low compare not on its pin");
endmodule
bind dpio_top dpio_top_chk dpio_top_chk_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .bus_i(bus_i), .rdata_o(rdata_o), .port_f_pin_i(port_f_pin_i),
   .port_e_drive_o(port_e_drive_o), .port_f_drive_o(port_f_drive_o),
   .timer_i(timer_i), .timer_ext_o(timer_ext_o));
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking testbench for the dual port I/O block.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import dpio_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   dpio_bus_req_t bus = '0;
   dpio_timer_in_t tmr = '0;
   logic [7:0] rdata, pin_e, pin_f, ext_e = 8'h00, ext_f = 8'h00;
   dpio_drive_t drv_e, drv_f;
   dpio_timer_ext_t t_ext;
   int err_count = 0, n_compared = 0, cyc = 0;
   dpio_top dpio_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus),
      .rdata_o(rdata), .port_e_pin_i(pin_e), .port_f_pin_i(pin_f),
      .port_e_drive_o(drv_e), .port_f_drive_o(drv_f), .timer_i(tmr), .timer_ext_o(t_ext));
   dpio_pins dpio_pins_e_inst (.drv_i(drv_e), .ext_i(ext_e), .pin_o(pin_e));
   dpio_pins dpio_pins_f_inst (.drv_i(drv_f), .ext_i(ext_f), .pin_o(pin_f));
   // The 250 MHz system clock.
   always #2 clk_sys_i = ~clk_sys_i;
   ////////////////////////////////////////////////////////////////////////////
   // Shared checking and bus tasks.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %h, expected %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      bus.wr <= 1'b0;
   endtask
   // The answer stands only in the cycle after the strobe, so it is looked at there.
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      bus.rd <= 1'b0;
      #1 chk(rdata, exp, "read data");
   endtask
   // Lets registered drivers and the pin synchroniser settle.
   task automatic settle();
      repeat (4) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic drv(input dpio_drive_t d, input logic [7:0] n, input logic [7:0] p);
      chk(d.nch_on, n, "n-channel drivers");
      chk(d.pch_on, p, "p-channel drivers");
      chk(d.pin_oe, n | p, "output enables");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset();
      settle();
      drv(drv_e, 8'h00, 8'h00);
      rd(OFS_PORT_E_OUT_VALUE, 8'h00);
      rd(OFS_PORT_F_OUT_VALUE, 8'h00);
      rd(OFS_PORT_E_DRV_TYPE, 8'h00);
      rd(OFS_PORT_F_DRV_TYPE, 8'h00);
      rd(4'h7, UNMAPPED_READ);
      $display("reset test done");
   endtask
   task automatic t_port_e();
      ext_e <= 8'ha5;
      wr(OFS_PORT_E_OUT_VALUE, 8'h0f);
      wr(OFS_PORT_E_DRV_TYPE, 8'h33);
      settle();
      drv(drv_e, 8'h00, 8'h00);
      rd(OFS_PORT_E_DIR_PIN, 8'ha5);
      wr(OFS_PORT_E_DIR_PIN, 8'hff);
      settle();
      drv(drv_e, 8'hf0, 8'h0c);
      rd(OFS_PORT_E_DIR_PIN, 8'h0d);
      rd(OFS_PORT_E_OUT_VALUE, 8'h0f);
      rd(OFS_PORT_E_DRV_TYPE, 8'h33);
      $display("port E test done");
   endtask
   task automatic t_port_f();
      ext_f <= 8'h33;
      wr(OFS_PORT_F_DRV_TYPE, 8'h04);
      wr(OFS_TIMER_PIN_SELECT, 8'h03);
      tmr <= '{timer_a_compare_out: 1'b1, timer_a_compare_output_select: 4'h1,
         timer_y_compare_output_select: 4'h2, default: '0};
      settle();
      drv(drv_f, 8'h80, 8'h00);
      wr(OFS_PORT_F_DRV_TYPE, 8'h00);
      settle();
      drv(drv_f, 8'h80, 8'h04);
      wr(OFS_TIMER_PIN_SELECT, 8'h01);
      tmr <= '{timer_a_compare_out: 1'b1, timer_a_compare_output_select: 4'h1,
         timer_x_compare_out: 1'b1, timer_x_compare_output_select: 4'h5,
         timer_b_compare_output_select: 4'h1, default: '0};
      settle();
      drv(drv_f, 8'h08, 8'h44);
      rd(OFS_PORT_F_DIR_PIN, 8'h77);
      chk({4'h0, t_ext}, 8'h0e, "timer inputs");
      wr(OFS_TIMER_PIN_SELECT, 8'h02);
      settle();
      chk({4'h0, t_ext}, 8'h0d, "timer inputs");
      $display("port F test done");
   endtask
   // A reset in mid-run brings written registers back; timers go quiet on the
   // edge that raises reset, so that no takeover straddles the release edge.
   task automatic t_mid_reset();
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      tmr <= '0;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      settle();
      drv(drv_e, 8'h00, 8'h00);
      drv(drv_f, 8'h00, 8'h00);
      rd(OFS_PORT_E_DIR_PIN, 8'ha5);
      rd(OFS_PORT_E_OUT_VALUE, 8'h00);
      rd(OFS_PORT_E_DRV_TYPE, 8'h00);
      $display("mid-run reset test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Verdict and the hang guard.
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_reset();
      t_port_e();
      t_port_f();
      t_mid_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
